// *** common/dsc_defs.vh ***
`ifndef DSC_DEFS_VH
`define DSC_DEFS_VH

// serial word layout
`define DSC_WORD_BITS      24
`define DSC_BITCNT_W       5
`define DSC_CTRL_HI        23
`define DSC_CTRL_LO        16
`define DSC_LOAD_HI_BIT    21
`define DSC_LOAD_LO_BIT    20
`define DSC_SEL_HI_BIT     18
`define DSC_SEL_LO_BIT     17
`define DSC_PDSEL_BIT      16
`define DSC_DATA_HI        15
`define DSC_DATA_LO        2
`define DSC_SAMPLE_W       14

// reference power command words, don't-care bits cleared
`define DSC_CMD_MASK       24'hfffffc
`define DSC_REF_OFF_WORD   24'h012000
`define DSC_REF_AUTO_WORD  24'h010000
`define DSC_REF_ON_WORD    24'h011000

// reference modes
`define DSC_REF_AUTO       2'h0
`define DSC_REF_ON         2'h1
`define DSC_REF_OFF        2'h2

// load actions
`define DSC_LOAD_STORE     2'h0
`define DSC_LOAD_UPD_ONE   2'h1
`define DSC_LOAD_UPD_ALL   2'h2
`define DSC_LOAD_BCAST     2'h3

// ahb register map (byte addresses)
`define DSC_REG_STATUS     4'h0
`define DSC_REG_CMD        4'h4
`define DSC_REG_LASTWORD   4'h8
`define DSC_REG_CHPD       4'hc

`endif

// *** logic/dsc_sync2.v ***
`timescale 1ns/1ps
// two-flop synchroniser for one level from outside the clock domain
module dsc_sync2 (
   input  wire clk,
   input  wire rst,
   input  wire din,
   output reg  dout
);
   reg meta_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b1;
         dout   <= 1'b1;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule // dsc_sync2

// *** logic/dsc_ref_ctrl.v ***
`timescale 1ns/1ps
`include "dsc_defs.vh"
// internal reference power control
module dsc_ref_ctrl (
   input  wire       clk,
   input  wire       rst,
   input  wire       set_valid,
   input  wire [1:0] set_mode,
   input  wire [3:0] ch_powered_down,
   output reg  [1:0] ref_mode,
   output reg        ref_enable,
   output reg        reference_output_pin_oe
);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_mode                <= `DSC_REF_AUTO;
         ref_enable              <= 1'b1;
         reference_output_pin_oe <= 1'b1;
      end else begin
         if (set_valid)
            ref_mode <= set_mode;
         case (ref_mode)
            `DSC_REF_OFF: begin
               ref_enable              <= 1'b0;
               reference_output_pin_oe <= 1'b0;
            end
            `DSC_REF_ON: begin
               ref_enable              <= 1'b1;
               reference_output_pin_oe <= 1'b1;
            end
            default: begin
               ref_enable              <= ~&ch_powered_down;
               reference_output_pin_oe <= ~&ch_powered_down;
            end
         endcase
      end
   end
endmodule // dsc_ref_ctrl

// *** logic/dsc_top.v ***
// Functional notes
// - after reset the internal reference is on in automatic mode.
// - word 012000h forces the reference off and releases its output pin.
// - word 010000h returns the reference to automatic mode.
// - word 011000h keeps the reference on regardless of channels.
// - automatic mode powers the reference down when every channel is down.
// - automatic mode powers the reference up when any channel is up.
// - reset restores automatic mode, same as the automatic-mode command.
// - 24-bit shift register: control byte, 14-bit sample, two ignored bits.
// - bits arrive most significant first, starting at bit 23.
// - data sampled on each of the first 24 falling serial clock edges inside a frame.
// - the 24th falling edge locks the word; extra edges are ignored.
// - the word is decoded at the 24th edge, not at frame end.
// - a new capture starts only at the next frame select fall.
// - frame ending early discards the partial word, no command runs.
// - sample is straight binary, 0 is zero, 3fffh is full scale less one.
// - load bits choose store, update one, update all or broadcast.
// - select bits pick channel a to d as destination.
// - power-down select bit marks power-down or reference command.
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dsc_defs.vh"
module dsc_top (
   input  wire        clk,
   input  wire        rst,
   input  wire        sclk,
   input  wire        frame_n,
   input  wire        sdin,
   output wire        reference_output_pin_oe,
   output wire        ref_enable,
   output reg         cmd_valid,
   output reg  [1:0]  cmd_load,
   output reg  [1:0]  cmd_chan,
   output reg         cmd_pd,
   output reg  [13:0] cmd_sample,
   output reg  [7:0]  cmd_ctrl,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hsel,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp
);
   wire sclk_s;
   wire frame_s;
   wire sdin_s;
   reg  sclk_q;
   reg  frame_q;

   dsc_sync2 u_sync_sclk (
      .clk  (clk),
      .rst  (rst),
      .din  (sclk),
      .dout (sclk_s)
   );
   dsc_sync2 u_sync_frame (
      .clk  (clk),
      .rst  (rst),
      .din  (frame_n),
      .dout (frame_s)
   );
   dsc_sync2 u_sync_din (
      .clk  (clk),
      .rst  (rst),
      .din  (sdin),
      .dout (sdin_s)
   );

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_q  <= 1'b1;
         frame_q <= 1'b1;
      end else begin
         sclk_q  <= sclk_s;
         frame_q <= frame_s;
      end
   end

   wire sclk_fall  = sclk_q & ~sclk_s;
   wire frame_fall = frame_q & ~frame_s;
   wire frame_rise = ~frame_q & frame_s;

   // serial receive: one-hot states
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_SHIFT = 3'b010;
   localparam [2:0] ST_LOCK  = 3'b100;

   reg [2:0]                 state_q;
   reg [`DSC_WORD_BITS-1:0]  shift_q;
   reg [`DSC_BITCNT_W-1:0]   bitcnt_q;
   reg                       word_done_q;
   reg [15:0]                frames_q;
   reg [15:0]                aborts_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q     <= ST_IDLE;
         shift_q     <= {`DSC_WORD_BITS{1'b0}};
         bitcnt_q    <= {`DSC_BITCNT_W{1'b0}};
         word_done_q <= 1'b0;
         aborts_q    <= 16'h0000;
      end else begin
         word_done_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (frame_fall) begin
                  state_q  <= ST_SHIFT;
                  bitcnt_q <= {`DSC_BITCNT_W{1'b0}};
               end
            end
            ST_SHIFT: begin
               if (frame_rise) begin
                  state_q  <= ST_IDLE;
                  aborts_q <= aborts_q + 16'h0001;
               end else if (sclk_fall) begin
                  shift_q  <= {shift_q[`DSC_WORD_BITS-2:0], sdin_s};
                  bitcnt_q <= bitcnt_q + 1'b1;
                  if (bitcnt_q == `DSC_WORD_BITS - 1) begin
                     state_q     <= ST_LOCK;
                     word_done_q <= 1'b1;
                  end
               end
            end
            ST_LOCK: begin
               // host keeps the gap; a fall after the lock restarts capture
               if (frame_fall) begin
                  state_q  <= ST_SHIFT;
                  bitcnt_q <= {`DSC_BITCNT_W{1'b0}};
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // field split of the locked word
   wire [7:0]  w_ctrl   = shift_q[`DSC_CTRL_HI:`DSC_CTRL_LO];
   wire [13:0] w_sample = shift_q[`DSC_DATA_HI:`DSC_DATA_LO];
   wire [`DSC_WORD_BITS-1:0] w_masked = shift_q & `DSC_CMD_MASK;

   reg       ref_set;
   reg [1:0] ref_set_mode;
   always @* begin
      ref_set      = 1'b0;
      ref_set_mode = `DSC_REF_AUTO;
      if (word_done_q) begin
         if (w_masked == `DSC_REF_OFF_WORD) begin
            ref_set      = 1'b1;
            ref_set_mode = `DSC_REF_OFF;
         end else if (w_masked == `DSC_REF_AUTO_WORD) begin
            ref_set      = 1'b1;
            ref_set_mode = `DSC_REF_AUTO;
         end else if (w_masked == `DSC_REF_ON_WORD) begin
            ref_set      = 1'b1;
            ref_set_mode = `DSC_REF_ON;
         end
      end
   end

   // channel power-down state, maintained from decoded words
   reg  [3:0] chpd_q;
   wire       is_pd = w_ctrl[`DSC_PDSEL_BIT-16];
   wire [1:0] sel   = w_ctrl[`DSC_SEL_HI_BIT-16:`DSC_SEL_LO_BIT-16];
   wire [1:0] load  = w_ctrl[`DSC_LOAD_HI_BIT-16:`DSC_LOAD_LO_BIT-16];
   // power-down modes sit in the top two sample bits; 00 means powered up
   wire       pd_req = |w_sample[13:12];

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_valid  <= 1'b0;
         cmd_load   <= 2'h0;
         cmd_chan   <= 2'h0;
         cmd_pd     <= 1'b0;
         cmd_sample <= 14'h0000;
         cmd_ctrl   <= 8'h00;
         chpd_q     <= 4'h0;
         frames_q   <= 16'h0000;
      end else begin
         cmd_valid <= word_done_q;
         if (word_done_q) begin
            frames_q <= frames_q + 16'h0001;
            cmd_load   <= load;
            cmd_chan   <= sel;
            cmd_pd     <= is_pd;
            cmd_sample <= w_sample;
            cmd_ctrl   <= w_ctrl;
            if (is_pd && !ref_set) begin
               if (load == `DSC_LOAD_BCAST)
                  chpd_q <= {4{pd_req}};
               else
                  chpd_q[sel] <= pd_req;
            end else if (!is_pd && load != `DSC_LOAD_STORE) begin
               // data loaded to a dac register powers that channel up
               chpd_q[sel] <= 1'b0;
            end
         end
      end
   end

   wire [1:0] ref_mode;
   dsc_ref_ctrl u_ref (
      .clk                     (clk),
      .rst                     (rst),
      .set_valid               (ref_set),
      .set_mode                (ref_set_mode),
      .ch_powered_down         (chpd_q),
      .ref_mode                (ref_mode),
      .ref_enable              (ref_enable),
      .reference_output_pin_oe (reference_output_pin_oe)
   );

   // ahb-lite slave, zero wait state, read-only status view
   wire rd_req  = hsel & hready & htrans[1] & ~hwrite;
   // only the first four words are mapped; aliases above them read as zero
   wire in_map  = (haddr[31:4] == 28'h0000000);

   // read data is captured at the address phase so the data phase sees a flop;
   // it shows the state one cycle before the data phase, which software cannot tell apart
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h00000000;
      end else begin
         hrdata <= 32'h00000000;
         if (rd_req && in_map) begin
            if (haddr[3:0] == `DSC_REG_STATUS) begin
               hrdata <= {20'h00000, aborts_q[3:0], 1'b0, state_q, ref_mode, ref_enable,
                          reference_output_pin_oe};
            end else if (haddr[3:0] == `DSC_REG_CMD) begin
               hrdata <= {frames_q, 2'h0, cmd_sample};
            end else if (haddr[3:0] == `DSC_REG_LASTWORD) begin
               hrdata <= {8'h00, shift_q};
            end else if (haddr[3:0] == `DSC_REG_CHPD) begin
               hrdata <= {28'h0000000, chpd_q};
            end else begin
               // unaligned offsets inside the map read as zero
               hrdata <= 32'h00000000;
            end
         end
      end
   end

   // writes are accepted and dropped: every register here is a status view

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
endmodule // dsc_top

// *** sim/dsc_props.sv ***
`timescale 1ns/1ps
`include "dsc_defs.vh"
module dsc_props (
   input wire        clk,
   input wire        rst,
   input wire        sclk,
   input wire        frame_n,
   input wire        reference_output_pin_oe,
   input wire        ref_enable,
   input wire        cmd_valid,
   input wire [1:0]  cmd_load,
   input wire [1:0]  cmd_chan,
   input wire        cmd_pd,
   input wire [13:0] cmd_sample,
   input wire [7:0]  cmd_ctrl,
   input wire        hreadyout,
   input wire        hresp
);
   logic       sclk_q;
   logic       fr_q;
   logic       got_q;
   logic [4:0] cnt_q;
   wire [23:0] word = {cmd_ctrl, cmd_sample, 2'h0};
   // raw pin falls per frame; held after frame end so a late pulse still sees it
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b1;
         fr_q   <= 1'b1;
         got_q  <= 1'b0;
         cnt_q  <= 5'h0;
      end else begin
         sclk_q <= sclk;
         fr_q   <= frame_n;
         if (fr_q && !frame_n) begin
            cnt_q <= 5'h0;
            got_q <= 1'b0;
         end else begin
            if (!frame_n && sclk_q && !sclk && cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h1;
            if (cmd_valid) got_q <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   rst_ref_on_a: assert property ($fell(rst) |-> ref_enable && reference_output_pin_oe)
      else $error("reference not on after reset");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   valid_pulse_a: assert property (cmd_valid |=> !cmd_valid)
      else $error("command pulse longer than one cycle");
   ref_off_a: assert property (cmd_valid && word == `DSC_REF_OFF_WORD
      |-> ##[1:3] (!ref_enable && !reference_output_pin_oe)) else $error("reference not off");
   ref_on_a: assert property (cmd_valid && word == `DSC_REF_ON_WORD
      |-> ##[1:3] ref_enable [*8]) else $error("reference not held on");
   field_map_a: assert property (cmd_valid |-> cmd_load == cmd_ctrl[5:4]
      && cmd_chan == cmd_ctrl[2:1] && cmd_pd == cmd_ctrl[0]) else $error("field split wrong");
   full_word_a: assert property (cmd_valid |-> cnt_q >= 5'h18)
      else $error("command from a short frame");
   word_exec_a: assert property ($rose(cnt_q == 5'h18) |-> ##[1:10] cmd_valid)
      else $error("word not executed after last bit");
   one_per_frame_a: assert property (cmd_valid |-> !got_q)
      else $error("second command in one frame");
   hold_word_a: assert property (!cmd_valid |-> $stable(word))
      else $error("command fields changed without a word");
   cover property (cmd_valid && word == `DSC_REF_OFF_WORD);
   cover property ($rose(frame_n) && cnt_q != 5'h0 && cnt_q < 5'h18);
   cover property (cnt_q == 5'h1a);
endmodule // dsc_props

bind dsc_top dsc_props u_props (.clk(clk), .rst(rst), .sclk(sclk), .frame_n(frame_n),
   .reference_output_pin_oe(reference_output_pin_oe), .ref_enable(ref_enable),
   .cmd_valid(cmd_valid), .cmd_load(cmd_load), .cmd_chan(cmd_chan), .cmd_pd(cmd_pd),
   .cmd_sample(cmd_sample), .cmd_ctrl(cmd_ctrl), .hreadyout(hreadyout), .hresp(hresp));

// *** sim/dsc_host_model.sv ***
`timescale 1ns/1ps
module dsc_host_model (
   output logic sclk,
   output logic frame_n,
   output logic sdin
);
   // serial clock stands high between frames
   initial begin
      sclk    = 1'b1;
      frame_n = 1'b1;
      sdin    = 1'b0;
   end
   task automatic send(input logic [23:0] w, input int nbits);
      int i;
      #7;
      frame_n = 1'b0;
      for (i = 0; i < nbits; i++) begin
         sdin = (i < 24) ? w[23 - i] : ~sdin;
         #160 sclk = 1'b0;
         #160 sclk = 1'b1;
      end
      // released data line toggles so a stale bit cannot look valid
      sdin = ~sdin;
      #160 frame_n = 1'b1;
      #480;
   endtask
endmodule // dsc_host_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`include "dsc_defs.vh"
module testbench;
   logic        clk, rst, hwrite, hsel, rdy_s;
   logic [31:0] haddr, hwdata, hr_s, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [23:0] w;
   logic [13:0] s;
   wire         sclk, frame_n, sdin, ref_oe, ref_en, cmd_valid, cmd_pd, hreadyout, hresp;
   wire  [1:0]  cmd_load, cmd_chan;
   wire  [13:0] cmd_sample;
   wire  [7:0]  cmd_ctrl;
   wire  [31:0] hrdata;
   int          n_errors, total_checks, n_valid, cycles, i;

   dsc_top i_dut (.clk(clk), .rst(rst), .sclk(sclk), .frame_n(frame_n), .sdin(sdin),
      .reference_output_pin_oe(ref_oe), .ref_enable(ref_en), .cmd_valid(cmd_valid),
      .cmd_load(cmd_load), .cmd_chan(cmd_chan), .cmd_pd(cmd_pd), .cmd_sample(cmd_sample),
      .cmd_ctrl(cmd_ctrl), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));
   dsc_host_model i_host (.sclk(sclk), .frame_n(frame_n), .sdin(sdin));

   initial clk = 1'b0;
   always #20 clk = ~clk;
   // copies taken at the edge avoid racing the design's own updates
   always @(posedge clk) begin
      hr_s    <= hrdata;
      rdy_s   <= hreadyout;
      n_valid <= n_valid + cmd_valid;
      cycles  <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsel   <= 1'b1;
      do begin @(posedge clk); #1; end while (!rdy_s);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      do begin @(posedge clk); #1; end while (!rdy_s);
      rd = hr_s;
   endtask
   task automatic frame(input logic [23:0] wd, input int nb);
      int v0;
      v0 = n_valid;
      i_host.send(wd, nb);
      @(posedge clk);
      #1;
      chk("pulses", n_valid - v0, (nb >= 24) ? 1 : 0);
   endtask
   task automatic ref_chk(input logic [1:0] m, input logic en);
      ahb(1'b0, 32'h0, 32'h0);
      chk("ref mode", (rd >> 2) & 32'h3, m);
      chk("ref enable", ref_en, en);
   endtask
   function automatic logic [23:0] mk(input logic [1:0] ld, input logic [1:0] ch,
                                      input logic pd, input logic [13:0] sm);
      return {2'h0, ld, 1'h0, ch, pd, sm, 2'h0};
   endfunction
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      rst = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
      hwdata = 32'h0; hsel = 1'b0; n_errors = 0; total_checks = 0; n_valid = 0; cycles = 0;
      w = $urandom(32'h6437f012);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      ahb(1'b0, 32'h0, 32'h0);
      chk("status", rd & 32'hf, 32'h3);
      for (i = 0; i < 9; i++) begin
         s = (i == 0) ? 14'h0 : (i == 1) ? 14'h3fff : 14'($urandom);
         w = mk(i[1:0], 2'($urandom), 1'b0, s) | 24'($urandom % 4);
         frame(w, (i == 8) ? 26 : 24);
         chk("ctrl", cmd_ctrl, w[23:16]);
         chk("sample", cmd_sample, s);
         chk("load", cmd_load, w[21:20]);
         chk("chan", cmd_chan, w[18:17]);
         chk("pd", cmd_pd, 1'b0);
      end
      frame(mk(2'h1, 2'h3, 1'b0, 14'h2aa), 10);
      chk("ctrl kept", cmd_ctrl, w[23:16]);
      $display("test data words ends");
      frame(`DSC_REF_OFF_WORD | 24'h3, 24);
      ref_chk(2'h2, 1'b0);
      chk("pin enable", ref_oe, 1'b0);
      frame(`DSC_REF_ON_WORD, 24);
      for (i = 0; i < 4; i++) frame(mk(2'h1, i[1:0], 1'b1, 14'h1000), 24);
      ref_chk(2'h1, 1'b1);
      frame(`DSC_REF_AUTO_WORD, 24);
      ref_chk(2'h0, 1'b0);
      frame(mk(2'h1, 2'h2, 1'b0, 14'h155), 24);
      ref_chk(2'h0, 1'b1);
      $display("test reference modes ends");
      frame(`DSC_REF_OFF_WORD, 24);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      ref_chk(2'h0, 1'b1);
      $display("test reset restore ends");
      ahb(1'b1, 32'h0, 32'hffffffff);
      ahb(1'b0, 32'h0, 32'h0);
      chk("status after write", rd & 32'hf, 32'h3);
      ahb(1'b0, 32'h10, 32'h0);
      chk("unmapped", rd, 32'h0);
      $display("test register bus ends");
      results();
   end
endmodule // testbench
